// [hw/home_seek_control.v]
// Home-seek control: start checks, profile capture, result handling, APB registers
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "home_seek_regs.vh"
module home_seek_control (
  input wire clock_i,
  input wire resetn_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire home_search_positive_pin_i,
  input wire home_search_negative_pin_i,
  input wire can_search_positive_i,
  input wire can_search_negative_i,
  input wire other_motion_i,
  input wire current_on_i,
  input wire alarm_active_i,
  input wire positive_limit_switch_assigned_i,
  input wire negative_limit_switch_assigned_i,
  input wire home_switch_assigned_i,
  input wire search_done_i,
  input wire search_ok_i,
  input wire motion_req_i,
  input wire wait_motion_complete_i,
  output wire motion_reject_o,
  output wire sequence_stall_o,
  output reg search_run_o,
  output reg search_dir_negative_o,
  output reg dir_from_driver_o,
  output reg [31:0] start_velocity_o,
  output reg [31:0] run_velocity_o,
  output reg [31:0] accel_time_o,
  output reg [31:0] decel_time_o,
  output wire [31:0] electrical_home_offset_o,
  output wire [31:0] position_command_o,
  output wire soft_limit_active_o,
  output wire moving_flag_o,
  output wire motion_end_flag_o,
  output wire home_found_flag_o,
  output wire home_found_output_o,
  output reg error_msg_o,
  output reg alarm_raise_o,
  output wire [7:0] alarm_code_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SEARCH = 1'b1;

  reg rst_s1_q;
  reg rst_n_q;
  wire rst_n;
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_n_q;

  wire [1:0] pin_lvl;
  pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .pin_i({home_search_negative_pin_i, home_search_positive_pin_i}),
    .level_o(pin_lvl)
  );

  // Pin starts act on the rising level only, so a held input starts once
  reg [1:0] pin_prev_q;
  wire [1:0] pin_rise = pin_lvl & ~pin_prev_q;

  reg [31:0] ctrl_q;
  reg [31:0] start_vel_q;
  reg [31:0] run_vel_q;
  reg [31:0] accel_q;
  reg [31:0] decel_q;
  reg [31:0] pos_lim_q;
  reg [31:0] neg_lim_q;
  reg [31:0] offset_q;
  reg [31:0] pos_cmd_q;
  reg state_q;
  reg found_q;
  reg limits_on_q;
  reg end_q;
  reg [7:0] code_q;

  wire [7:0] addr = paddr_i[7:0];
  wire addr_hi_zero = (paddr_i[31:8] == 24'h00_0000);
  wire access = psel_i && penable_i;
  wire wr = access && pwrite_i && ce_i;
  reg mapped;
  reg [31:0] rdata;

  wire [3:0] pattern = ctrl_q[`HS_CTRL_PAT_MSB:`HS_CTRL_PAT_LSB];
  wire soft_limit_enable = ctrl_q[`HS_CTRL_SLE_BIT];
  wire searching = (state_q == ST_SEARCH);

  // Start requests; software command takes priority over pin, pin over CANopen
  wire cmd_wr = wr && (addr == `HS_OFF_CMD) && addr_hi_zero;
  wire cmd_pos = cmd_wr && pwdata_i[`HS_CMD_POS_BIT];
  wire cmd_neg = cmd_wr && pwdata_i[`HS_CMD_NEG_BIT] && !pwdata_i[`HS_CMD_POS_BIT];
  wire cmd_seq = pwdata_i[`HS_CMD_SEQ_BIT];
  wire any_cmd = cmd_pos || cmd_neg;
  wire pin_pos = pin_rise[0];
  wire pin_neg = pin_rise[1] && !pin_rise[0];
  wire can_pos = can_search_positive_i;
  wire can_neg = can_search_negative_i && !can_search_positive_i;
  wire start_req = any_cmd || pin_pos || pin_neg || can_pos || can_neg;
  reg start_neg;
  always @*
  begin
    if (any_cmd)
    begin
      start_neg = cmd_neg;
    end
    else if (pin_pos || pin_neg)
    begin
      start_neg = pin_neg;
    end
    else
    begin
      start_neg = can_neg;
    end
  end
  wire from_seq = any_cmd && cmd_seq;

  // Signal requirements per pattern; driver-directed pattern needs none
  reg need_lim;
  reg need_home;
  always @*
  begin
    case (pattern)
      `HS_PAT_ALL_SIGNALS:
      begin
        need_lim = 1'b1;
        need_home = 1'b1;
      end
      `HS_PAT_DRIVER_DIR:
      begin
        need_lim = 1'b0;
        need_home = 1'b0;
      end
      default:
      begin
        need_lim = 1'b1;
        need_home = 1'b0;
      end
    endcase
  end
  wire lim_ok = positive_limit_switch_assigned_i && negative_limit_switch_assigned_i;
  wire signals_ok = (!need_lim || lim_ok) && (!need_home || home_switch_assigned_i);
  wire busy_block = searching || other_motion_i || !current_on_i || alarm_active_i;
  wire start_ok = start_req && !busy_block && signals_ok;
  wire start_bad = start_req && !start_ok;

  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      pin_prev_q <= 2'b00;
      found_q <= 1'b0;
      limits_on_q <= 1'b0;
      end_q <= 1'b0;
      code_q <= `HS_ALARM_NONE;
      search_run_o <= 1'b0;
      search_dir_negative_o <= 1'b0;
      dir_from_driver_o <= 1'b0;
      start_velocity_o <= `HS_VEL_RST;
      run_velocity_o <= `HS_VEL_RST;
      accel_time_o <= `HS_VEL_RST;
      decel_time_o <= `HS_VEL_RST;
      error_msg_o <= 1'b0;
      alarm_raise_o <= 1'b0;
      ctrl_q <= `HS_CTRL_RST;
      start_vel_q <= `HS_VEL_RST;
      run_vel_q <= `HS_VEL_RST;
      accel_q <= `HS_VEL_RST;
      decel_q <= `HS_VEL_RST;
      pos_lim_q <= `HS_VEL_RST;
      neg_lim_q <= `HS_VEL_RST;
      offset_q <= `HS_VEL_RST;
      pos_cmd_q <= `HS_VEL_RST;
    end
    else if (ce_i)
    begin
      pin_prev_q <= pin_lvl;
      error_msg_o <= 1'b0;
      alarm_raise_o <= 1'b0;
      if (wr && addr_hi_zero)
      begin
        case (addr)
          `HS_OFF_CTRL: ctrl_q <= pwdata_i;
          `HS_OFF_START_VEL: start_vel_q <= pwdata_i;
          `HS_OFF_RUN_VEL: run_vel_q <= pwdata_i;
          `HS_OFF_ACCEL: accel_q <= pwdata_i;
          `HS_OFF_DECEL: decel_q <= pwdata_i;
          `HS_OFF_POS_LIMIT: pos_lim_q <= pwdata_i;
          `HS_OFF_NEG_LIMIT: neg_lim_q <= pwdata_i;
          `HS_OFF_OFFSET: offset_q <= pwdata_i;
          `HS_OFF_POS_CMD: pos_cmd_q <= pwdata_i;
          default:
          begin
          end
        endcase
      end
      if (start_bad)
      begin
        if (from_seq)
        begin
          alarm_raise_o <= 1'b1;
          code_q <= signals_ok ? `HS_ALARM_BUSY : `HS_ALARM_SIGNALS;
        end
        else
        begin
          error_msg_o <= 1'b1;
        end
      end
      case (state_q)
        ST_IDLE:
        begin
          if (start_ok)
          begin
            state_q <= ST_SEARCH;
            search_run_o <= 1'b1;
            end_q <= 1'b0;
            found_q <= 1'b0;
            limits_on_q <= 1'b0;
            search_dir_negative_o <= start_neg;
            dir_from_driver_o <= (pattern == `HS_PAT_DRIVER_DIR);
            start_velocity_o <= start_vel_q;
            run_velocity_o <= run_vel_q;
            accel_time_o <= accel_q;
            decel_time_o <= decel_q;
          end
        end
        ST_SEARCH:
        begin
          if (search_done_i)
          begin
            state_q <= ST_IDLE;
            search_run_o <= 1'b0;
            end_q <= 1'b1;
            if (search_ok_i)
            begin
              pos_cmd_q <= 32'h0000_0000;
              found_q <= 1'b1;
              limits_on_q <= soft_limit_enable && ((pos_lim_q != 32'h0000_0000)
                || (neg_lim_q != 32'h0000_0000));
            end
            else
            begin
              found_q <= 1'b0;
            end
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always @*
  begin
    mapped = addr_hi_zero;
    rdata = 32'h0000_0000;
    case (addr)
      `HS_OFF_CTRL: rdata = ctrl_q;
      `HS_OFF_CMD: rdata = 32'h0000_0000;
      `HS_OFF_STATUS:
      begin
        rdata[`HS_ST_MOVING_BIT] = searching;
        rdata[`HS_ST_END_BIT] = end_q;
        rdata[`HS_ST_FOUND_BIT] = found_q;
        rdata[`HS_ST_LIMACT_BIT] = soft_limit_active_o;
        rdata[`HS_ST_SEARCH_BIT] = searching;
        rdata[`HS_ST_CODE_MSB:`HS_ST_CODE_LSB] = code_q;
      end
      `HS_OFF_START_VEL: rdata = start_vel_q;
      `HS_OFF_RUN_VEL: rdata = run_vel_q;
      `HS_OFF_ACCEL: rdata = accel_q;
      `HS_OFF_DECEL: rdata = decel_q;
      `HS_OFF_POS_LIMIT: rdata = pos_lim_q;
      `HS_OFF_NEG_LIMIT: rdata = neg_lim_q;
      `HS_OFF_OFFSET: rdata = offset_q;
      `HS_OFF_POS_CMD: rdata = pos_cmd_q;
      default: mapped = 1'b0;
    endcase
    if (!addr_hi_zero)
    begin
      rdata = 32'h0000_0000;
    end
  end

  // Zero-wait slave: every access completes in its first access cycle
  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;
  assign prdata_o = (access && !pwrite_i) ? rdata : 32'h0000_0000;

  assign motion_reject_o = motion_req_i && searching;
  // A sequence waiting on motion complete holds while any motion, this search included, is under way
  assign sequence_stall_o = wait_motion_complete_i && (searching || other_motion_i);
  assign soft_limit_active_o = limits_on_q && !searching;
  assign moving_flag_o = searching;
  assign motion_end_flag_o = end_q;
  assign home_found_flag_o = found_q;
  assign home_found_output_o = found_q;
  assign electrical_home_offset_o = offset_q;
  assign position_command_o = pos_cmd_q;
  assign alarm_code_o = code_q;
endmodule // home_seek_control
`default_nettype wire

// [hw/home_seek_regs.vh]
// Register offsets, fields, reset values and codes for home-seek control
`ifndef HOME_SEEK_REGS_VH
`define HOME_SEEK_REGS_VH
`define HS_ADDR_W 8
`define HS_OFF_CTRL 8'h00
`define HS_OFF_CMD 8'h04
`define HS_OFF_STATUS 8'h08
`define HS_OFF_START_VEL 8'h0C
`define HS_OFF_RUN_VEL 8'h10
`define HS_OFF_ACCEL 8'h14
`define HS_OFF_DECEL 8'h18
`define HS_OFF_POS_LIMIT 8'h1C
`define HS_OFF_NEG_LIMIT 8'h20
`define HS_OFF_OFFSET 8'h24
`define HS_OFF_POS_CMD 8'h28
`define HS_CTRL_SLE_BIT 0
`define HS_CTRL_PAT_LSB 4
`define HS_CTRL_PAT_MSB 7
`define HS_CMD_POS_BIT 0
`define HS_CMD_NEG_BIT 1
`define HS_CMD_SEQ_BIT 2
`define HS_ST_MOVING_BIT 0
`define HS_ST_END_BIT 1
`define HS_ST_FOUND_BIT 2
`define HS_ST_LIMACT_BIT 3
`define HS_ST_SEARCH_BIT 4
`define HS_ST_CODE_LSB 8
`define HS_ST_CODE_MSB 15
`define HS_CTRL_RST 32'h0000_0000
`define HS_VEL_RST 32'h0000_0000
`define HS_ALARM_BUSY 8'hA0
`define HS_ALARM_SIGNALS 8'h70
`define HS_ALARM_NONE 8'h00
`define HS_PAT_ALL_SIGNALS 4'h4
`define HS_PAT_DRIVER_DIR 4'hC
`define HS_SYNC_STAGES 3
`endif

// [hw/pin_sync.v]
// Three-stage pin synchroniser with agreement filter, one instance per bit group
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter WIDTH = 4
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      always @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end
        else if (ce_i)
        begin
          s1_q <= pin_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Only accepted once two later stages agree
          if (s2_q == s3_q)
          begin
            lvl_q <= s3_q;
          end
        end
      end
      assign level_o[g] = lvl_q;
    end
  endgenerate
endmodule // pin_sync
`default_nettype wire

// [sim/home_seek_checker.sv]
// Port checker for home-seek control
`timescale 1ns/1ns
`default_nettype none
module home_seek_checker (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic motion_req_i,
  input wire logic other_motion_i,
  input wire logic current_on_i,
  input wire logic alarm_active_i,
  input wire logic search_done_i,
  input wire logic search_ok_i,
  input wire logic motion_reject_o,
  input wire logic search_run_o,
  input wire logic [31:0] start_velocity_o,
  input wire logic [31:0] run_velocity_o,
  input wire logic [31:0] position_command_o,
  input wire logic soft_limit_active_o,
  input wire logic motion_end_flag_o,
  input wire logic home_found_flag_o,
  input wire logic home_found_output_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  a_reject_search:
    assert property (motion_reject_o == (motion_req_i && search_run_o)) else $error("reject");
  a_limits_off:
    assert property (search_run_o |-> !soft_limit_active_o) else $error("limits on");
  a_found_output:
    assert property (ce_i && search_run_o && search_done_i && search_ok_i
      |=> home_found_output_o) else $error("found output");
  a_success_zero:
    assert property (ce_i && search_run_o && search_done_i && search_ok_i
      |=> position_command_o == 32'h0 && home_found_flag_o) else $error("success");
  a_fail_keeps:
    assert property (ce_i && search_run_o && search_done_i && !search_ok_i
      |=> !home_found_flag_o) else $error("fail");
  a_profile_held:
    assert property (search_run_o && $past(search_run_o)
      |-> $stable(start_velocity_o) && $stable(run_velocity_o)) else $error("profile");
  a_refuse_start:
    assert property (ce_i && !search_run_o && (other_motion_i || !current_on_i || alarm_active_i)
      |=> !search_run_o) else $error("start taken");
  a_end_flags:
    assert property (ce_i && search_run_o && search_done_i
      |=> !search_run_o && motion_end_flag_o) else $error("end");
  cover property (search_run_o && search_done_i && search_ok_i);
  cover property (search_run_o && search_done_i && !search_ok_i);
  cover property (motion_reject_o);
endmodule // home_seek_checker
`default_nettype wire

// [sim/driver_model.sv]
// Motor driver model: ends each search after a set delay
`timescale 1ns/1ns
`default_nettype none
module driver_model (
  input wire logic clock_i,
  input wire logic run_i,
  input wire logic good_i,
  input wire logic [3:0] delay_i,
  output logic done_o,
  output logic ok_o
);
  logic [3:0] cnt_q = 4'h0;
  initial done_o = 1'h0;
  initial ok_o = 1'h0;
  always @(posedge clock_i)
  begin
    done_o <= 1'h0;
    // Result is junk outside the done pulse
    ok_o <= ~ok_o;
    if (!run_i)
      cnt_q <= delay_i;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    else if (!done_o)
    begin
      done_o <= 1'h1;
      ok_o <= good_i;
    end
  end
endmodule // driver_model
`default_nettype wire

// [sim/testbench.sv]
// Testbench: home-seek control against a driver model
`timescale 1ns/1ns
`default_nettype none
`include "home_seek_regs.vh"
module testbench;
  logic clock_i = 0, resetn_i = 0, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [31:0] paddr_i = 0, pwdata_i = 0, lfsr = 32'h5348CAB8, rd, v[4];
  logic home_search_positive_pin_i = 0, home_search_negative_pin_i = 0, err, p12 = 0;
  logic can_search_positive_i = 0, can_search_negative_i = 0, other_motion_i = 0;
  logic current_on_i = 1, alarm_active_i = 0, positive_limit_switch_assigned_i = 1;
  logic negative_limit_switch_assigned_i = 1, home_switch_assigned_i = 1, good = 1;
  logic motion_req_i = 0, wait_motion_complete_i = 0;
  logic [3:0] dly = 4'h9;
  wire search_done_i, search_ok_i, pready_o, pslverr_o, motion_reject_o, sequence_stall_o;
  wire search_run_o, search_dir_negative_o, dir_from_driver_o, soft_limit_active_o;
  wire moving_flag_o, motion_end_flag_o, home_found_flag_o, home_found_output_o;
  wire error_msg_o, alarm_raise_o;
  wire [7:0] alarm_code_o;
  wire [31:0] prdata_o, start_velocity_o, run_velocity_o, accel_time_o, decel_time_o;
  wire [31:0] electrical_home_offset_o, position_command_o;
  int bad_count = 0, num_checks = 0, cyc = 0;
  home_seek_control dut (.*);
  driver_model drv (.clock_i(clock_i), .run_i(search_run_o), .good_i(good), .delay_i(dly),
    .done_o(search_done_i), .ok_o(search_ok_i));
  initial forever #5 clock_i = ~clock_i;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic results;
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      results();
    end
  end
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'h1;
    @(posedge clock_i);
    while (pready_o !== 1'h1)
    begin
      @(posedge clock_i);
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    #1;
  endtask
  // how: 0/4 pin negative/positive, 1/2 command positive/negative, 3/5 CANopen pos/neg
  task automatic seek(input logic [2:0] how, input logic ok, input logic lim,
    input logic [31:0] pos);
    int n;
    n = 0;
    lfsr = nxt(lfsr);
    good <= ok;
    dly <= 4'h8 | lfsr[2:0];
    case (how)
      3'h0: home_search_negative_pin_i <= 1'h1;
      3'h4: home_search_positive_pin_i <= 1'h1;
      3'h3, 3'h5:
      begin
        @(posedge clock_i);
        can_search_positive_i <= (how == 3'h3);
        can_search_negative_i <= (how == 3'h5);
        @(posedge clock_i);
        can_search_positive_i <= 1'h0;
        can_search_negative_i <= 1'h0;
      end
      default: apb(1'h1, `HS_OFF_CMD, {29'h0, how});
    endcase
    while (search_run_o !== 1'h1 && n < 9)
    begin
      @(posedge clock_i);
      n++;
    end
    #1;
    chk(search_run_o, 1);
    chk(search_dir_negative_o, how == 3'h0 || how == 3'h2 || how == 3'h5);
    chk(dir_from_driver_o, p12);
    chk(soft_limit_active_o, 0);
    chk(start_velocity_o, v[0]);
    chk(decel_time_o, v[3]);
    chk(run_velocity_o, v[1]);
    chk(accel_time_o, v[2]);
    chk({moving_flag_o, motion_end_flag_o, home_found_flag_o}, 3'h4);
    v[0] = ~v[0];
    apb(1'h1, `HS_OFF_START_VEL, v[0]);
    chk(start_velocity_o, ~v[0]);
    // A second start while searching is refused, the search goes on
    apb(1'h1, `HS_OFF_CMD, 32'h1);
    chk({search_run_o, error_msg_o, alarm_raise_o}, 3'h6);
    motion_req_i <= 1'h1;
    wait_motion_complete_i <= 1'h1;
    #1;
    chk({motion_reject_o, sequence_stall_o}, 2'h3);
    n = 0;
    while (moving_flag_o === 1'h1 && n < 40)
    begin
      @(posedge clock_i);
      n++;
    end
    #1;
    chk({motion_reject_o, sequence_stall_o, motion_end_flag_o}, 3'h1);
    chk(home_found_flag_o, ok);
    chk(home_found_output_o, ok);
    chk(position_command_o, pos);
    if (ok)
      chk(soft_limit_active_o, lim);
    motion_req_i <= 1'h0;
    wait_motion_complete_i <= 1'h0;
    home_search_negative_pin_i <= 1'h0;
    home_search_positive_pin_i <= 1'h0;
  endtask
  initial
  begin
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'h1;
    repeat (3) @(posedge clock_i);
    apb(1'h0, `HS_OFF_CTRL, 0);
    chk(rd, `HS_CTRL_RST);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      v[i] = lfsr;
      apb(1'h1, `HS_OFF_START_VEL + 4 * i, lfsr);
    end
    apb(1'h1, `HS_OFF_OFFSET, v[1]);
    chk(electrical_home_offset_o, v[1]);
    apb(1'h1, `HS_OFF_CTRL, 32'h1);
    apb(1'h1, `HS_OFF_POS_LIMIT, 32'h64);
    apb(1'h1, `HS_OFF_POS_CMD, 32'h55);
    seek(3'h1, 1'h1, 1'h1, 0);
    apb(1'h0, `HS_OFF_STATUS, 0);
    chk(rd[4:0], 5'h0E);
    apb(1'h0, `HS_OFF_OFFSET, 0);
    chk(rd, v[1]);
    apb(1'h1, `HS_OFF_POS_CMD, 32'h77);
    seek(3'h2, 1'h0, 1'h0, 32'h77);
    // Both limits zero keeps them off
    apb(1'h1, `HS_OFF_POS_LIMIT, 0);
    seek(3'h0, 1'h1, 1'h0, 0);
    apb(1'h1, `HS_OFF_CTRL, 32'hC1);
    p12 = 1;
    seek(3'h3, 1'h1, 1'h0, 0);
    apb(1'h1, `HS_OFF_POS_CMD, 32'h33);
    seek(3'h5, 1'h0, 1'h0, 32'h33);
    // A nonzero negative limit alone re-enables limits
    apb(1'h1, `HS_OFF_NEG_LIMIT, 32'hFFFF_FF00);
    seek(3'h4, 1'h1, 1'h1, 0);
    p12 = 0;
    apb(1'h1, `HS_OFF_CTRL, 32'h41);
    wait_motion_complete_i <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      other_motion_i <= (i % 4 == 0);
      current_on_i <= (i % 4 != 1);
      alarm_active_i <= (i % 4 == 2);
      home_switch_assigned_i <= (i != 3);
      positive_limit_switch_assigned_i <= (i != 7);
      apb(1'h1, `HS_OFF_CMD, (i < 4) ? 32'h2 : 32'h6);
      chk(search_run_o, 0);
      chk({error_msg_o, alarm_raise_o}, (i < 4) ? 2'h2 : 2'h1);
      chk(sequence_stall_o, i % 4 == 0);
      if (i > 3)
        chk(alarm_code_o, (i == 7) ? `HS_ALARM_SIGNALS : `HS_ALARM_BUSY);
    end
    wait_motion_complete_i <= 1'h0;
    positive_limit_switch_assigned_i <= 1'h1;
    home_switch_assigned_i <= 1'h1;
    // Clock enable low: writes and starts are both ignored
    ce_i <= 1'h0;
    apb(1'h1, `HS_OFF_CTRL, 0);
    can_search_positive_i <= 1'h1;
    @(posedge clock_i);
    can_search_positive_i <= 1'h0;
    #1;
    chk({search_run_o, error_msg_o}, 2'h0);
    ce_i <= 1'h1;
    apb(1'h0, `HS_OFF_CTRL, 0);
    chk(rd, 32'h41);
    apb(1'h0, 32'h30, 0);
    chk(err, 1);
    chk(rd, 0);
    results();
  end
endmodule // testbench
bind home_seek_control home_seek_checker watch (.*);
`default_nettype wire
